// ### hdl/wdc_capture.sv
// Downconverter, bank capture and linked-list DMA of the wideband capture block
//
// Overview of operation
// RULE1: Single mode decimates by 8, 16 or 32.
// RULE2: Dual mode shares one decimation of 4, 8, 16.
// RULE3: Each dual channel has own 32-bit tuning.
// RULE4: Each filter uses its own 16-bit coefficients.
// RULE5: Default coefficient set is built in.
// RULE6: Outputs 16-bit I and Q at decimated rate.
// RULE7: Source is converter or test generator.
// RULE8: FIFO mode and transient capture mode exist.
// RULE9: Single mode spreads data over four banks.
// RULE10: Dual mode: channel one banks 1-2, two 3-4.
// RULE11: Capture keeps full rate, drops nothing.
// RULE12: Each bank addresses 512 MB.
// RULE13: DMA walks a linked descriptor list.
// RULE14: Gate-driven descriptor ends with the gate.
// RULE15: Optional metadata: time stamp and length.
// RULE16: TTL input acts as gate, PPS or sync.
// RULE17: Oscillator is a wrapping 32-bit phase accumulator.
// RULE18: Time stamp is sample count at capture start.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module wdc_capture (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire wdc_pkg::wdc_reg_type reg_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [1:0][wdc_pkg::SMP_W-1:0] adc_i,
  input wire logic ttl_i,
  output wdc_pkg::wdc_iq_type [1:0] iq_o,
  output wdc_pkg::wdc_bwr_type [wdc_pkg::NBANK-1:0] bank_wr_o,
  output wdc_pkg::wdc_brd_type bank_rd_o,
  input wire wdc_pkg::wdc_word_type mem_rd_i,
  output wdc_pkg::wdc_pcie_type pcie_o
);
  import wdc_pkg::*;

  typedef struct packed {
    logic dual;
    logic src_test;
    logic fifo;
    logic arm;
    logic [1:0] dec;
    wdc_ttl_type ttlf;
    logic dflt;
    logic [1:0][TUNE_W-1:0] tune;
    logic [BADDR_W-1:0] cap_len;
    logic [31:0] desc_lo;
    logic [DIDX_W-1:0] desc_idx;
    logic ttl;
    logic active;
    logic done;
    logic [31:0] smp_cnt;
    logic [31:0] pps_time;
    logic [31:0] cap_time;
    logic [SMP_W-1:0] ramp;
    logic [1:0][TUNE_W-1:0] phase;
    logic [COEF_AW-1:0] j;
    logic jl;
    logic [1:0][MIX_W-1:0] mi;
    logic [1:0][MIX_W-1:0] mq;
    logic [1:0][ACC_W-1:0] acc_i;
    logic [1:0][ACC_W-1:0] acc_q;
    wdc_iq_type [1:0] iq;
    logic [1:0] rot;
    logic alt;
    logic ph;
    logic [1:0][SMP_W-1:0] hold;
    logic [NBANK-1:0][BADDR_W-1:0] wptr;
    wdc_bwr_type [NBANK-1:0] bwr;
    wdc_dma_type dst;
    logic [DIDX_W-1:0] dra;
    wdc_desc_type dd;
    logic [BADDR_W-1:0] rptr;
    logic [BADDR_W-1:0] dcnt;
    wdc_brd_type brd;
    wdc_pcie_type pcie;
    logic [31:0] rdata;
  } wdc_state_type;

  wdc_state_type q, n;
  logic [1:0][SMP_W-1:0] smp;
  logic [1:0][COEF_W-1:0] coef_rd;
  logic [1:0][COEF_W-1:0] coef;
  logic [DESC_W-1:0] desc_rd;
  logic coef_wr;
  logic desc_wr;
  logic want;
  logic rise;
  logic dma_end;
  logic [COEF_AW-1:0] jlast;
  logic [TUNE_W-1:0] ph1;
  logic signed [36:0] ti;
  logic signed [36:0] tq;
  logic [ACC_W-1:0] si;
  logic [ACC_W-1:0] sq;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sixteen-step cosine table indexed by the top phase bits
  function automatic logic signed [7:0] lo_val(input logic [3:0] idx);
    logic signed [7:0] m;
    m = 8'sh00;
    unique case (idx[2:0])
      3'h0: m = 8'sh7F;
      3'h1: m = 8'sh75;
      3'h2: m = 8'sh5A;
      3'h3: m = 8'sh31;
      3'h4: m = 8'sh00;
      3'h5: m = -8'sh31;
      3'h6: m = -8'sh5A;
      3'h7: m = -8'sh75;
    endcase
    return idx[3] ? -m : m;
  endfunction

  function automatic logic [MIX_W-1:0] mix(input logic [SMP_W-1:0] x, input logic [3:0] idx);
    logic signed [19:0] p;
    p = $signed(x) * lo_val(idx);
    return MIX_W'(p);
  endfunction

  function automatic logic [15:0] ext16(input logic [SMP_W-1:0] x);
    return {{4{x[SMP_W-1]}}, x};
  endfunction

  // Clocks per output: 4, 8 or 16 (two samples a clock in single mode)
  function automatic logic [COEF_AW-1:0] cyc_last(input logic [1:0] code);
    logic [1:0] c;
    c = (code == 2'h3) ? 2'h2 : code;
    return COEF_AW'((5'h04 << c) - 5'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Coefficient and descriptor memories

  assign coef_wr = reg_i.wr && (reg_i.addr == REG_COEF);
  assign desc_wr = reg_i.wr && (reg_i.addr == REG_DESC_HI);

  for (genvar c = 0; c < 2; c++)
  begin : g_coef
    wdc_ram #(.W(COEF_W), .D(COEF_DEPTH), .AW(COEF_AW)) u_coef (
      .sys_clk_i(sys_clk_i),
      .wr_i(coef_wr && (reg_i.wdata[COEF_SEL] == c[0])),
      .waddr_i(reg_i.wdata[COEF_IDX +: COEF_AW]),
      .wdata_i(reg_i.wdata[COEF_W-1:0]),
      .raddr_i(q.j),
      .rdata_o(coef_rd[c])
    );
    assign coef[c] = q.dflt ? DEFAULT_COEF : coef_rd[c]; // RULE4 RULE5
  end

  wdc_ram #(.W(DESC_W), .D(DESC_DEPTH), .AW(DIDX_W)) u_desc (
    .sys_clk_i(sys_clk_i),
    .wr_i(desc_wr),
    .waddr_i(q.desc_idx),
    .wdata_i({reg_i.wdata, q.desc_lo}),
    .raddr_i(q.dra),
    .rdata_o(desc_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    n = q;
    n.rdata = '0;
    n.bwr = '0;
    n.brd = '0;
    n.pcie = '0;
    ti = '0;
    tq = '0;
    si = '0;
    sq = '0;
    dma_end = 1'b0;
    // Register writes come first so that hardware events below win
    if (reg_i.wr)
    begin
      unique case (reg_i.addr)
        REG_CTRL:
        begin
          n.dual = reg_i.wdata[CTRL_DUAL];
          n.src_test = reg_i.wdata[CTRL_TEST];
          n.fifo = reg_i.wdata[CTRL_FIFO];
          n.arm = reg_i.wdata[CTRL_ARM];
          n.dec = reg_i.wdata[CTRL_DEC +: 2];
          n.ttlf = wdc_ttl_type'(reg_i.wdata[CTRL_TTL +: 2]);
          n.dflt = reg_i.wdata[CTRL_DFLT];
          if (!reg_i.wdata[CTRL_ARM])
          begin
            n.done = 1'b0;
          end
        end
        REG_TUNE0: n.tune[0] = reg_i.wdata;
        REG_TUNE1: n.tune[1] = reg_i.wdata;
        REG_CAP_LEN: n.cap_len = reg_i.wdata[BADDR_W-1:0];
        REG_DESC_LO: n.desc_lo = reg_i.wdata;
        REG_DESC_IDX: n.desc_idx = reg_i.wdata[DIDX_W-1:0];
        default: ;
      endcase
    end
    if (reg_i.rd)
    begin
      unique case (reg_i.addr)
        REG_CTRL: n.rdata = {21'h0, q.dflt, 2'h0, q.ttlf, q.dec, q.arm, q.fifo, q.src_test, q.dual};
        REG_TUNE0: n.rdata = q.tune[0];
        REG_TUNE1: n.rdata = q.tune[1];
        REG_CAP_LEN: n.rdata = {5'h0, q.cap_len};
        REG_DESC_LO: n.rdata = q.desc_lo;
        REG_DESC_IDX: n.rdata = {27'h0, q.desc_idx};
        REG_STATUS: n.rdata = {28'h0, q.ttl, (q.dst != D_IDLE), q.done, q.active};
        REG_PPS_TIME: n.rdata = q.pps_time;
        REG_SMP_CNT: n.rdata = q.smp_cnt;
        default: n.rdata = '0;
      endcase
    end

    // Timing input and sample counter
    n.ttl = ttl_i;
    n.smp_cnt = q.smp_cnt + (q.dual ? 32'h1 : 32'h2);
    n.ramp = q.ramp + RAMP_STEP;
    if (rise && (q.ttlf == TTL_PPS))
    begin
      n.pps_time = q.smp_cnt; // RULE16
    end

    // Downconverter front: oscillator and mixer
    n.phase[0] = q.phase[0] + (q.dual ? q.tune[0] : {q.tune[0][TUNE_W-2:0], 1'b0}); // RULE17 RULE3
    n.phase[1] = q.dual ? q.phase[1] + q.tune[1] : q.phase[1];
    n.mi[0] = mix(smp[0], q.phase[0][31:28]) + (q.dual ? '0 : mix(smp[1], ph1[31:28]));
    n.mq[0] = mix(smp[0], q.phase[0][31:28] + 4'h4) + (q.dual ? '0 : mix(smp[1], ph1[31:28] + 4'h4));
    n.mi[1] = q.dual ? mix(smp[1], q.phase[1][31:28]) : '0;
    n.mq[1] = q.dual ? mix(smp[1], q.phase[1][31:28] + 4'h4) : '0;
    n.jl = (q.j == jlast);
    n.j = n.jl ? '0 : q.j + 4'h1; // RULE1 RULE2

    // Downconverter back: filter and decimate
    for (int c = 0; c < 2; c++)
    begin
      ti = $signed(q.mi[c]) * $signed(coef[c]);
      tq = $signed(q.mq[c]) * $signed(coef[c]);
      si = q.acc_i[c] + ACC_W'(ti);
      sq = q.acc_q[c] + ACC_W'(tq);
      n.iq[c] = '0;
      if (q.jl)
      begin
        n.iq[c].valid = (c == 0) || q.dual; // RULE6
        n.iq[c].i = si[ACC_W-1 -: IQ_W];
        n.iq[c].q = sq[ACC_W-1 -: IQ_W];
        n.acc_i[c] = '0;
        n.acc_q[c] = '0;
      end
      else
      begin
        n.acc_i[c] = si;
        n.acc_q[c] = sq;
      end
    end
    if (rise && (q.ttlf == TTL_SYNC))
    begin
      n.smp_cnt = '0; // RULE16
      n.phase = '0;
      n.j = '0;
    end

    // Acquisition into the banks
    if (want && !q.active)
    begin
      n.active = 1'b1;
      n.wptr = '0;
      n.cap_time = q.smp_cnt; // RULE18
      n.rot = '0;
      n.ph = 1'b0;
      n.alt = 1'b0;
    end
    else if (q.active && !want)
    begin
      n.active = 1'b0;
    end
    else if (q.active && !q.fifo && (q.wptr[NBANK-1] == q.cap_len))
    begin
      n.active = 1'b0; // RULE8
      n.done = 1'b1;
    end
    else if (q.active && !q.dual)
    begin
      n.bwr[q.rot] = '{en: 1'b1, addr: q.wptr[q.rot], data: {ext16(smp[1]), ext16(smp[0])}}; // RULE9 RULE11
      n.wptr[q.rot] = q.wptr[q.rot] + 1'b1; // RULE12
      n.rot = q.rot + 2'h1;
    end
    else if (q.active)
    begin
      n.ph = !q.ph;
      n.hold = smp;
      if (q.ph)
      begin
        n.bwr[{1'b0, q.alt}] = '{en: 1'b1, addr: q.wptr[{1'b0, q.alt}], data: {ext16(smp[0]), ext16(q.hold[0])}}; // RULE10
        n.bwr[{1'b1, q.alt}] = '{en: 1'b1, addr: q.wptr[{1'b1, q.alt}], data: {ext16(smp[1]), ext16(q.hold[1])}};
        n.wptr[{1'b0, q.alt}] = q.wptr[{1'b0, q.alt}] + 1'b1;
        n.wptr[{1'b1, q.alt}] = q.wptr[{1'b1, q.alt}] + 1'b1;
        n.alt = !q.alt;
      end
    end

    // Linked-list DMA
    if (mem_rd_i.valid)
    begin
      n.pcie = '{valid: 1'b1, meta: 1'b0, data: mem_rd_i.data};
    end
    unique case (q.dst)
      D_IDLE:
      begin
        if (reg_i.wr && (reg_i.addr == REG_DMA_HEAD))
        begin
          n.dra = reg_i.wdata[DIDX_W-1:0];
          n.dst = D_FETCH;
        end
      end
      D_FETCH: n.dst = D_LOAD;
      D_LOAD:
      begin
        n.dd = wdc_desc_type'(desc_rd); // RULE13
        n.rptr = desc_rd[BADDR_W-1:0];
        n.dcnt = '0;
        n.dst = D_READ;
      end
      D_READ:
      begin
        if (q.dd.gated ? (q.rptr != q.wptr[q.dd.bank]) : (q.dcnt != q.dd.len))
        begin
          n.brd = '{en: 1'b1, bank: q.dd.bank, addr: q.rptr};
          n.rptr = q.rptr + 1'b1;
          n.dcnt = q.dcnt + 1'b1;
        end
        else if (!q.dd.gated || !q.active)
        begin
          dma_end = !q.dd.meta; // RULE14
          n.dst = q.dd.meta ? D_TS : D_READ;
        end
      end
      D_TS:
      begin
        if (!mem_rd_i.valid)
        begin
          n.pcie = '{valid: 1'b1, meta: 1'b1, data: q.cap_time}; // RULE15
          n.dst = D_LEN;
        end
      end
      D_LEN:
      begin
        if (!mem_rd_i.valid)
        begin
          n.pcie = '{valid: 1'b1, meta: 1'b1, data: {5'h0, q.dcnt}};
          dma_end = 1'b1;
        end
      end
      default: n.dst = D_IDLE;
    endcase
    if (dma_end)
    begin
      n.dra = q.dd.next;
      n.dst = q.dd.last ? D_IDLE : D_FETCH; // RULE13
    end
  end

  assign smp[0] = q.src_test ? q.ramp : adc_i[0]; // RULE7
  assign smp[1] = q.src_test ? q.ramp + 12'h001 : adc_i[1];
  assign ph1 = q.phase[0] + q.tune[0];
  assign jlast = cyc_last(q.dec);
  assign rise = ttl_i && !q.ttl;
  assign want = q.arm && !q.done && ((q.ttlf != TTL_GATE) || ttl_i); // RULE16

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
      q.dflt <= CTRL_RST[CTRL_DFLT];
    end
    else
    begin
      q <= n;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign iq_o = q.iq;
  assign bank_wr_o = q.bwr;
  assign bank_rd_o = q.brd;
  assign pcie_o = q.pcie;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [4:0] gap_q;
  always_ff @(posedge sys_clk_i)
  begin
    gap_q <= (!rst_n_i || q.iq[0].valid) ? 5'h01 : gap_q + 5'h01;
  end

  // Cycles since the decimation code last changed; the output grid needs two blocks to settle
  logic [5:0] dec_age_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || (n.dec != q.dec))
    begin
      dec_age_q <= 6'h00;
    end
    else if (dec_age_q != 6'h3F)
    begin
      dec_age_q <= dec_age_q + 6'h01;
    end
  end

  phase_step_a: assert property (q.dual && !rise && $past(q.dual) && $past(rst_n_i) |=> // RULE17
    q.phase[1] == $past(q.phase[1]) + $past(q.tune[1]))
    else $error("phase accumulator step wrong");
  out_rate_a: assert property (q.iq[0].valid && (dec_age_q == 6'h3F) |-> // RULE1
    gap_q == 5'(jlast) + 5'h01)
    else $error("decimated output spacing wrong");
  dual_pair_a: assert property (q.dual && q.bwr[0].en |-> q.bwr[2].en && !q.bwr[1].en) // RULE10
    else $error("dual mode bank routing wrong");
  single_rot_a: assert property (!q.dual && q.bwr[0].en && q.active && !$changed(q.dual) |=> // RULE9
    q.bwr[1].en || !q.active)
    else $error("single mode bank rotation wrong");
  full_rate_a: assert property (!q.dual && $past(q.active) && q.active && $stable(q.dual) |-> // RULE11
    (q.bwr[0].en || q.bwr[1].en || q.bwr[2].en || q.bwr[3].en))
    else $error("sample dropped during capture");
  trans_stop_a: assert property (q.active && !q.fifo && q.wptr[3] == q.cap_len && want |=> // RULE8
    !q.active && q.done)
    else $error("transient capture did not stop");
  gate_end_a: assert property (q.dst == D_READ && q.dd.gated && !q.active && // RULE14
    q.rptr == q.wptr[q.dd.bank] |=> q.dst != D_READ)
    else $error("gated transfer did not end");
  meta_word_a: assert property (q.dst == D_TS && !mem_rd_i.valid |=> // RULE15
    pcie_o.valid && pcie_o.meta && pcie_o.data == $past(q.cap_time) ##1 (pcie_o.meta || $past(mem_rd_i.valid)))
    else $error("metadata packet wrong");
  src_sel_a: assert property (q.src_test && q.active && !q.dual && !q.fifo && q.wptr[3] != q.cap_len |=> // RULE7
    bank_wr_o[$past(q.rot)].data[15:0] == ext16($past(q.ramp)))
    else $error("test source not selected");
endmodule

// ### hdl/wdc_pkg.sv
// Package: constants and carrier types for the wideband capture block
package wdc_pkg;
  localparam int SMP_W = 12;
  localparam int IQ_W = 16;
  localparam int TUNE_W = 32;
  localparam int COEF_W = 16;
  localparam int COEF_DEPTH = 16;
  localparam int COEF_AW = 4;
  localparam int MIX_W = 21;
  localparam int ACC_W = 41;
  localparam longint BANK_BYTES = 64'd536870912;
  localparam int WORD_BYTES = 4;
  localparam int BADDR_W = 27;
  localparam int NBANK = 4;
  localparam int DESC_DEPTH = 32;
  localparam int DIDX_W = 5;
  localparam int DESC_W = 64;
  localparam int RADDR_W = 6;
  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [RADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [RADDR_W-1:0] REG_TUNE0 = 6'h04;
  localparam logic [RADDR_W-1:0] REG_TUNE1 = 6'h08;
  localparam logic [RADDR_W-1:0] REG_CAP_LEN = 6'h0C;
  localparam logic [RADDR_W-1:0] REG_COEF = 6'h10;
  localparam logic [RADDR_W-1:0] REG_DESC_LO = 6'h14;
  localparam logic [RADDR_W-1:0] REG_DESC_HI = 6'h18;
  localparam logic [RADDR_W-1:0] REG_DESC_IDX = 6'h1C;
  localparam logic [RADDR_W-1:0] REG_DMA_HEAD = 6'h20;
  localparam logic [RADDR_W-1:0] REG_STATUS = 6'h24;
  localparam logic [RADDR_W-1:0] REG_PPS_TIME = 6'h28;
  localparam logic [RADDR_W-1:0] REG_SMP_CNT = 6'h2C;
  // Control field positions
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_TEST = 1;
  localparam int CTRL_FIFO = 2;
  localparam int CTRL_ARM = 3;
  localparam int CTRL_DEC = 4;
  localparam int CTRL_TTL = 6;
  localparam int CTRL_DFLT = 10;
  localparam int COEF_SEL = 31;
  localparam int COEF_IDX = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0400;
  localparam logic [COEF_W-1:0] DEFAULT_COEF = 16'h0400;
  localparam logic [SMP_W-1:0] RAMP_STEP = 12'h002;
  typedef enum logic [1:0] {TTL_GATE = 2'b00, TTL_PPS = 2'b01, TTL_SYNC = 2'b10} wdc_ttl_type;
  typedef enum logic [2:0] {D_IDLE = 3'b000, D_FETCH = 3'b001, D_LOAD = 3'b010, D_READ = 3'b011,
    D_TS = 3'b100, D_LEN = 3'b101} wdc_dma_type;
  typedef struct packed {logic wr; logic rd; logic [RADDR_W-1:0] addr; logic [31:0] wdata;} wdc_reg_type;
  typedef struct packed {logic valid; logic [IQ_W-1:0] i; logic [IQ_W-1:0] q;} wdc_iq_type;
  typedef struct packed {logic en; logic [BADDR_W-1:0] addr; logic [31:0] data;} wdc_bwr_type;
  typedef struct packed {logic en; logic [1:0] bank; logic [BADDR_W-1:0] addr;} wdc_brd_type;
  typedef struct packed {logic valid; logic [31:0] data;} wdc_word_type;
  typedef struct packed {logic valid; logic meta; logic [31:0] data;} wdc_pcie_type;
  typedef struct packed {logic last; logic gated; logic meta; logic [1:0] bank; logic [DIDX_W-1:0] next;
    logic [BADDR_W-1:0] len; logic [BADDR_W-1:0] addr;} wdc_desc_type;
endpackage

// ### hdl/wdc_ram.sv
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
module wdc_ram #(
  parameter int W = 16,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_q [D];

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule

// ### verif/wdc_far_model.sv
// Converter and memory-bank model facing the capture block
`timescale 1ns/1ps
module wdc_far_model #(
  parameter int LAT = 3
) (
  input wire logic sys_clk_i,
  input wire wdc_pkg::wdc_bwr_type [wdc_pkg::NBANK-1:0] bank_wr_i,
  input wire wdc_pkg::wdc_brd_type bank_rd_i,
  output logic [1:0][wdc_pkg::SMP_W-1:0] adc_o,
  output wdc_pkg::wdc_word_type mem_rd_o
);
  import wdc_pkg::*;
  logic [31:0] mem [NBANK][16];
  logic [10:0] cnt;
  wdc_brd_type pipe [LAT];
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cnt = '0;
    adc_o = '0;
    mem_rd_o = '0;
    foreach (pipe[i]) pipe[i] = '0;
  end
  // Lane 0 ramps up with its sign bit clear, lane 1 ramps up with its sign bit set, so each lane is recognisable in the banks
  always @(posedge sys_clk_i)
  begin
    cnt <= cnt + 11'h001;
    adc_o <= {{1'b1, cnt}, {1'b0, cnt}};
    for (int b = 0; b < NBANK; b++)
      if (bank_wr_i[b].en)
        mem[b][bank_wr_i[b].addr[3:0]] <= bank_wr_i[b].data;
    pipe[0] <= bank_rd_i;
    for (int i = 1; i < LAT; i++)
      pipe[i] <= pipe[i-1];
    // Idle return bus inverts its data every idle cycle, so it alternates between the last word and its inverse
    if (pipe[LAT-1].en)
      mem_rd_o <= '{1'b1, mem[pipe[LAT-1].bank][pipe[LAT-1].addr[3:0]]};
    else
      mem_rd_o <= '{1'b0, ~mem_rd_o.data};
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the wideband capture block
`timescale 1ns/1ps
module testbench;
  import wdc_pkg::*;
  logic sys_clk_i;
  logic rst_n_i;
  wdc_reg_type rq;
  logic [31:0] rdata;
  logic [1:0][SMP_W-1:0] adc;
  logic ttl;
  wdc_iq_type [1:0] iq;
  wdc_bwr_type [NBANK-1:0] bwr;
  wdc_brd_type brd;
  wdc_word_type mrd;
  wdc_pcie_type pcie;
  int error_cnt;
  int checks_done;
  int cyc;
  int k;
  int nrd;
  int nb [NBANK];
  logic dual;
  logic [10:0] prev;
  logic [31:0] pq [$];
  logic [31:0] mq [$];
  wdc_capture dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_i(rq), .reg_rdata_o(rdata), .adc_i(adc),
    .ttl_i(ttl), .iq_o(iq), .bank_wr_o(bwr), .bank_rd_o(brd), .mem_rd_i(mrd), .pcie_o(pcie));
  wdc_far_model #(.LAT(3)) far (.sys_clk_i(sys_clk_i), .bank_wr_i(bwr), .bank_rd_i(brd), .adc_o(adc),
    .mem_rd_o(mrd));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic reg_wr(input logic [RADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk_i) rq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_i) rq <= '0;
  endtask
  task automatic rd_chk(input logic [RADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i) rq <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge sys_clk_i) rq <= '0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic wait_iq(input int l, output int t);
    int n;
    n = 0;
    tick(1);
    while (iq[l].valid !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    t = cyc;
  endtask
  task automatic gap(input int l, input int exp);
    int t0;
    int t1;
    wait_iq(l, t0);
    wait_iq(l, t0);
    wait_iq(l, t1);
    chk(t1 - t0, exp);
  endtask
  task automatic clr(input logic m);
    k = 0;
    nrd = 0;
    dual = m;
    foreach (nb[i]) nb[i] = 0;
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Monitors sample at the falling edge, clear of the launching edge
  always @(negedge sys_clk_i)
  begin
    if (rst_n_i && (bwr[0].en | bwr[1].en | bwr[2].en | bwr[3].en))
    begin
      chk({bwr[3].en, bwr[2].en, bwr[1].en, bwr[0].en}, dual ? (k % 2 ? 4'hA : 4'h5) : 4'h1 << (k % 4));
      for (int b = 0; b < NBANK; b++)
        if (bwr[b].en)
        begin
          chk(bwr[b].addr, 32'(nb[b]));
          chk({bwr[b].data[31:27], bwr[b].data[15:11]}, !dual ? 10'h3E0 : (b < 2 ? 10'h000 : 10'h3FF));
          chk(11'(bwr[b].data[26:16] - bwr[b].data[10:0]), 32'(dual));
          if (!dual && k > 0)
            chk(11'(bwr[b].data[10:0] - prev), 32'h1);
          prev = bwr[b].data[10:0];
          nb[b]++;
        end
      k++;
    end
    if (rst_n_i && pcie.valid === 1'b1)
      if (pcie.meta)
        mq.push_back(pcie.data);
      else
        pq.push_back(pcie.data);
    if (rst_n_i && brd.en === 1'b1)
    begin
      chk({brd.bank, 3'h0, brd.addr}, {2'h1, 30'(nrd)});
      nrd++;
    end
  end
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] v;
    int n;
    int t;
    rst_n_i = 1'b0;
    rq = '0;
    ttl = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    prev = '0;
    clr(1'b0);
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(REG_CTRL, CTRL_RST);
    rd_chk(6'h3C, 32'h0);
    reg_wr(REG_STATUS, 32'hFFFF_FFFF);
    rd_chk(REG_STATUS, 32'h0);
    tick(0);
    chk(rdata, 32'h0);
    // Output rate for both modes and decimation codes 0 to 2
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 3; c++)
      begin
        reg_wr(REG_CTRL, CTRL_RST | m | (c << CTRL_DEC));
        gap(0, 4 << c);
        if (m == 1)
          gap(1, 4 << c);
      end
    // Channel 0 coefficients zero, channel 1 flat
    for (int j = 0; j < 32; j++)
      reg_wr(REG_COEF, {j[4], 11'h000, j[3:0], j[4] ? 16'h0400 : 16'h0000});
    reg_wr(REG_CTRL, 32'h0000_0001);
    repeat (3) wait_iq(1, t);
    chk(iq[1].i !== 16'h0000, 32'h1);
    wait_iq(0, t);
    chk(iq[0].i, 32'h0);
    reg_wr(REG_TUNE0, 32'h89AB_CDEF);
    reg_wr(REG_TUNE1, 32'h1234_5670);
    rd_chk(REG_TUNE0, 32'h89AB_CDEF);
    rd_chk(REG_TUNE1, 32'h1234_5670);
    // Single-channel transient capture of three words per bank
    reg_wr(REG_CTRL, CTRL_RST);
    clr(1'b0);
    reg_wr(REG_CAP_LEN, 32'h3);
    @(posedge sys_clk_i) rq <= '{1'b0, 1'b1, REG_SMP_CNT, 32'h0000_0000};
    @(posedge sys_clk_i) rq <= '{1'b1, 1'b0, REG_CTRL, 32'h0000_0448};
    #1 v = rdata;
    @(posedge sys_clk_i) rq <= '0;
    tick(40);
    for (int b = 0; b < NBANK; b++)
      chk(nb[b], 3);
    rd_chk(REG_STATUS, 32'h2);
    // One descriptor from bank 2 with metadata
    reg_wr(REG_DESC_IDX, 32'h0);
    reg_wr(REG_DESC_LO, 32'h1800_0000);
    reg_wr(REG_DESC_HI, 32'hA800_0000);
    reg_wr(REG_DMA_HEAD, 32'h0);
    n = 1;
    tick(1);
    while (brd.en !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(n, 3);
    tick(30);
    chk(nrd, 3);
    chk(pq.size(), 3);
    for (int i = 0; i < pq.size(); i++)
      chk(pq[i], far.mem[1][i]);
    chk(mq.size(), 2);
    chk(mq[1], 32'h3);
    chk((mq[0] - v) <= 32'd10, 32'h1);
    // Dual-channel FIFO capture under the gate
    reg_wr(REG_CTRL, CTRL_RST);
    clr(1'b1);
    reg_wr(REG_CTRL, 32'h0000_040D);
    tick(20);
    chk(k, 0);
    @(posedge sys_clk_i) ttl <= 1'b1;
    tick(40);
    rd_chk(REG_STATUS, 32'h9);
    chk(k > 12, 32'h1);
    @(posedge sys_clk_i) ttl <= 1'b0;
    tick(5);
    t = k;
    tick(20);
    chk(k, t);
    // Gate-driven descriptor on bank 2 reads as many words as the gated capture wrote there
    t = nb[1];
    clr(1'b1);
    reg_wr(REG_DESC_IDX, 32'h1);
    reg_wr(REG_DESC_LO, 32'h0);
    reg_wr(REG_DESC_HI, 32'hC800_0000);
    reg_wr(REG_DMA_HEAD, 32'h1);
    tick(t + 20);
    chk(nrd, t);
    rd_chk(REG_STATUS, 32'h0);
    reg_wr(REG_CTRL, CTRL_RST);
    close_out;
  end
endmodule
